/* inc/mbr_pkg.sv */
// Shared constants, field table and carrier types of the multi-byte register front end.
package mbr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Access widths.
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int FIELD_MAX_BYTES = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Field map: byte base addresses of every field.
    localparam logic [15:0] DCO_WORD_BASE = 16'h0010;
    localparam logic [15:0] LOCK_THR_BASE = 16'h0020;
    localparam logic [15:0] PIN_CFG_BASE = 16'h0030;
    localparam logic [15:0] REFIN_CFG_BASE = 16'h0031;
    localparam logic [15:0] OUTDIV_BASE = 16'h0040;
    localparam logic [15:0] OUTDIV_STRIDE = 16'h0008;
    localparam int OUTDIV_INST = 4;

    // Field indices inside the bank.
    localparam int FLD_DCO = 0;
    localparam int FLD_LOCK = 1;
    localparam int FLD_PIN = 2;
    localparam int FLD_REFIN = 3;
    localparam int FLD_OUTDIV0 = 4;
    localparam int FLD_NUM = FLD_OUTDIV0 + OUTDIV_INST;

    // Width in bytes, atomic flag and value after reset of each field.
    localparam int FLD_BYTES [FLD_NUM] = '{4, 2, 1, 1, 2, 2, 2, 2};
    localparam bit FLD_ATOMIC [FLD_NUM] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    localparam logic [31:0] PIN_CFG_RST = 32'h0000000c;
    localparam logic [31:0] REFIN_CFG_RST = 32'h00000001;
    localparam logic [31:0] FLD_RESET [FLD_NUM] = '{32'h00000000, 32'h00000000, PIN_CFG_RST,
        REFIN_CFG_RST, 32'h00000001, 32'h00000001, 32'h00000001, 32'h00000001};

    ////////////////////////////////////////////////////////////////////////////////
    // Bit positions inside the pin and reference-input configuration bytes.
    localparam int PIN_OE_SEL_LSB = 0;
    localparam int PIN_POL_BIT = 2;
    localparam int PIN_PU_BIT = 3;
    localparam int PIN_PD_BIT = 4;
    localparam int REFIN_EN_BIT = 0;
    localparam int REFIN_DCB_BIT = 1;
    localparam int REFIN_SEB_BIT = 2;
    localparam logic [1:0] OE_SEL_PIN = 2'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Carrier types.
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [7:0] data;
    } mbr_wr_s;

    typedef struct packed {
        logic [1:0] oe_sel;
        logic oe_pol;
        logic pu;
        logic pd;
    } mbr_pin_cfg_s;

    typedef struct packed {
        logic [31:0] dco_word;
        logic [15:0] lock_thresh;
        logic [3:0][15:0] outdiv;
    } mbr_fields_s;

endpackage

/* core/mbr_field_reg.sv */
// One multi-byte register field with lane select and optional atomic staging.
`timescale 1ns/1ps

module mbr_field_reg #(
    parameter logic [15:0] BASE = 16'h0000,
    parameter int NBYTES = 2,
    parameter bit ATOMIC = 1'b0,
    parameter logic [31:0] RESET_VAL = 32'h00000000
) (
    input wire logic clk,
    input wire logic reset_n,
    input mbr_pkg::mbr_wr_s wr,
    output logic hit,
    output logic apply,
    output logic [31:0] value_q
);

    logic [15:0] offset;
    logic [1:0] lane;
    logic msb_write;
    logic [31:0] stage_q;
    logic [31:0] value_d;

    if (NBYTES < 1 || NBYTES > mbr_pkg::FIELD_MAX_BYTES)
    begin : g_bad_width
        $error("mbr_field_reg: NBYTES must be 1 to 4");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Byte lane is the distance from the field base; byte 0 is the least significant.
    assign offset = wr.addr - BASE;
    assign hit = wr.valid && (wr.addr >= BASE) && (offset < 16'(NBYTES));
    assign lane = offset[1:0];
    assign msb_write = hit && (lane == 2'(NBYTES - 1));
    // An atomic field only moves on its top byte; a plain one moves on every byte.
    assign apply = ATOMIC ? msb_write : hit;

    ////////////////////////////////////////////////////////////////////////////////
    // Lower bytes of an atomic field wait here; reset value keeps a lone top-byte write sane.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            stage_q <= RESET_VAL;
        end
        else if (ATOMIC && hit && !msb_write)
        begin
            stage_q[lane * 8 +: 8] <= wr.data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next applied value, bit 0 of each byte at its lowest index.
    always_comb
    begin
        value_d = value_q;
        for (int b = 0; b < mbr_pkg::FIELD_MAX_BYTES; b++)
        begin
            if (b < NBYTES)
            begin
                if (!ATOMIC)
                begin
                    if (hit && lane == 2'(b))
                    begin
                        value_d[b * 8 +: 8] = wr.data;
                    end
                end
                else if (msb_write)
                begin
                    // Whole field lands at once, top byte from the bus, the rest from staging.
                    value_d[b * 8 +: 8] = (b == NBYTES - 1) ? wr.data : stage_q[b * 8 +: 8];
                end
            end
        end
    end

    // Applied value seen by the internal logic.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            value_q <= RESET_VAL;
        end
        else
        begin
            value_q <= value_d;
        end
    end

endmodule

/* core/mbr_pin_ctrl.sv */
// Shared enable / chip-select pin: synchroniser, mode decode, output enable and pad pulls.
`timescale 1ns/1ps

module mbr_pin_ctrl (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic shared_pin,
    input wire logic spi_mode_pin,
    input mbr_pkg::mbr_pin_cfg_s cfg,
    output logic spi_mode_q,
    output logic selected_q,
    output logic outputs_enable_q,
    output logic pullup_q,
    output logic pulldown_q
);

    logic pin_meta_q;
    logic pin_sync_q;
    logic mode_meta_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Both pins are asynchronous; the first stage feeds only the second.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pin_meta_q <= 1'b1;
            pin_sync_q <= 1'b1;
            mode_meta_q <= 1'b0;
            spi_mode_q <= 1'b0;
        end
        else
        begin
            pin_meta_q <= shared_pin;
            pin_sync_q <= pin_meta_q;
            mode_meta_q <= spi_mode_pin;
            spi_mode_q <= mode_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Chip select is active low and only means something in serial-peripheral mode.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            selected_q <= 1'b0;
        end
        else
        begin
            selected_q <= spi_mode_q && !pin_sync_q;
        end
    end

    // In two-wire mode the pin gates all clock outputs when the source select is zero.
    // Any other source select, or the chip-select role, leaves the outputs enabled here.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            outputs_enable_q <= 1'b1;
        end
        else if (!spi_mode_q && cfg.oe_sel == mbr_pkg::OE_SEL_PIN)
        begin
            outputs_enable_q <= (pin_sync_q == cfg.oe_pol);
        end
        else
        begin
            outputs_enable_q <= 1'b1;
        end
    end

    // Pad pulls follow their own fields in two-wire mode; a select pin idles pulled high.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pullup_q <= 1'b1;
            pulldown_q <= 1'b0;
        end
        else if (!spi_mode_q)
        begin
            pullup_q <= cfg.pu;
            pulldown_q <= cfg.pd;
        end
        else
        begin
            pullup_q <= 1'b1;
            pulldown_q <= 1'b0;
        end
    end

endmodule

/* core/mbr_field_bank.sv */
// Register field bank behind the serial port: byte lanes, atomic fields, repeated blocks, pin and input controls.
`timescale 1ns/1ps

module mbr_field_bank (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic spi_mode_pin,
    input wire logic shared_enable_select_pin,
    input wire logic wr_valid,
    input wire logic [15:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [15:0] rd_addr,
    output logic [7:0] rd_data_q,
    output logic rd_mapped_q,
    output logic wr_miss_q,
    output logic [mbr_pkg::FLD_NUM-1:0] field_applied_q,
    output mbr_pkg::mbr_fields_s fields_q,
    output logic spi_mode_q,
    output logic device_selected_q,
    output logic clock_outputs_enable_q,
    output logic enable_pin_pullup_on_q,
    output logic enable_pin_pulldown_on_q,
    output logic ref_buffer_enable_q,
    output logic differential_ac_bias_on_q,
    output logic single_ended_bias_on_q
);

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration checks: the field carrier is built for four divider instances.
    if (mbr_pkg::OUTDIV_INST != 4)
    begin : g_bad_inst
        $error("mbr_field_bank: carrier holds exactly four divider instances");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Field base address by index; divider instances are spaced by the block stride.
    function automatic logic [15:0] fld_base(input int idx);
        logic [15:0] base;
        case (idx)
            mbr_pkg::FLD_DCO: base = mbr_pkg::DCO_WORD_BASE;
            mbr_pkg::FLD_LOCK: base = mbr_pkg::LOCK_THR_BASE;
            mbr_pkg::FLD_PIN: base = mbr_pkg::PIN_CFG_BASE;
            mbr_pkg::FLD_REFIN: base = mbr_pkg::REFIN_CFG_BASE;
            default: base = mbr_pkg::OUTDIV_BASE + 16'(idx - mbr_pkg::FLD_OUTDIV0) * mbr_pkg::OUTDIV_STRIDE;
        endcase
        return base;
    endfunction

    mbr_pkg::mbr_wr_s wr_gated;
    mbr_pkg::mbr_pin_cfg_s pin_cfg;
    logic [31:0] fld_val [mbr_pkg::FLD_NUM];
    logic [mbr_pkg::FLD_NUM-1:0] fld_hit;
    logic [mbr_pkg::FLD_NUM-1:0] fld_apply;
    logic [7:0] rd_data_d;
    logic rd_mapped_d;
    logic [15:0] rd_off;

    ////////////////////////////////////////////////////////////////////////////////
    // Write qualification: in serial-peripheral mode the select must already be seen low.
    // The select passes a synchroniser, so the serial engine must hold it a few cycles ahead.
    always_comb
    begin
        wr_gated.valid = wr_valid && (!spi_mode_q || device_selected_q);
        wr_gated.addr = wr_addr;
        wr_gated.data = wr_data;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One field register per entry of the table.
    for (genvar i = 0; i < mbr_pkg::FLD_NUM; i++)
    begin : g_field
        mbr_field_reg #(
            .BASE(fld_base(i)),
            .NBYTES(mbr_pkg::FLD_BYTES[i]),
            .ATOMIC(mbr_pkg::FLD_ATOMIC[i]),
            .RESET_VAL(mbr_pkg::FLD_RESET[i])
        ) u_field (
            .clk(clk),
            .reset_n(reset_n),
            .wr(wr_gated),
            .hit(fld_hit[i]),
            .apply(fld_apply[i]),
            .value_q(fld_val[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Applied fields as seen by the internal configuration logic.
    assign fields_q.dco_word = fld_val[mbr_pkg::FLD_DCO];
    assign fields_q.lock_thresh = fld_val[mbr_pkg::FLD_LOCK][15:0];
    for (genvar k = 0; k < mbr_pkg::OUTDIV_INST; k++)
    begin : g_outdiv
        assign fields_q.outdiv[k] = fld_val[mbr_pkg::FLD_OUTDIV0 + k][15:0];
    end

    // Pin configuration fields unpacked from their byte.
    assign pin_cfg.oe_sel = fld_val[mbr_pkg::FLD_PIN][mbr_pkg::PIN_OE_SEL_LSB +: 2];
    assign pin_cfg.oe_pol = fld_val[mbr_pkg::FLD_PIN][mbr_pkg::PIN_POL_BIT];
    assign pin_cfg.pu = fld_val[mbr_pkg::FLD_PIN][mbr_pkg::PIN_PU_BIT];
    assign pin_cfg.pd = fld_val[mbr_pkg::FLD_PIN][mbr_pkg::PIN_PD_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Shared pin handling.
    mbr_pin_ctrl u_pin (
        .clk(clk),
        .reset_n(reset_n),
        .shared_pin(shared_enable_select_pin),
        .spi_mode_pin(spi_mode_pin),
        .cfg(pin_cfg),
        .spi_mode_q(spi_mode_q),
        .selected_q(device_selected_q),
        .outputs_enable_q(clock_outputs_enable_q),
        .pullup_q(enable_pin_pullup_on_q),
        .pulldown_q(enable_pin_pulldown_on_q)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Reference input buffer; biasing is dropped while the buffer is off to save power.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ref_buffer_enable_q <= mbr_pkg::REFIN_CFG_RST[mbr_pkg::REFIN_EN_BIT];
            differential_ac_bias_on_q <= mbr_pkg::REFIN_CFG_RST[mbr_pkg::REFIN_DCB_BIT];
            single_ended_bias_on_q <= mbr_pkg::REFIN_CFG_RST[mbr_pkg::REFIN_SEB_BIT];
        end
        else
        begin
            ref_buffer_enable_q <= fld_val[mbr_pkg::FLD_REFIN][mbr_pkg::REFIN_EN_BIT];
            differential_ac_bias_on_q <= fld_val[mbr_pkg::FLD_REFIN][mbr_pkg::REFIN_EN_BIT] &&
                fld_val[mbr_pkg::FLD_REFIN][mbr_pkg::REFIN_DCB_BIT];
            single_ended_bias_on_q <= fld_val[mbr_pkg::FLD_REFIN][mbr_pkg::REFIN_EN_BIT] &&
                fld_val[mbr_pkg::FLD_REFIN][mbr_pkg::REFIN_SEB_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Apply strobes and unmapped-write flag, one cycle each, aligned with the new values.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            field_applied_q <= '0;
            wr_miss_q <= 1'b0;
        end
        else
        begin
            field_applied_q <= fld_apply;
            wr_miss_q <= wr_gated.valid && (fld_hit == '0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read back of applied values; staged atomic bytes are not visible until applied.
    always_comb
    begin
        rd_data_d = 8'h00;
        rd_mapped_d = 1'b0;
        rd_off = 16'h0000;
        for (int i = 0; i < mbr_pkg::FLD_NUM; i++)
        begin
            rd_off = rd_addr - fld_base(i);
            if (rd_addr >= fld_base(i) && rd_off < 16'(mbr_pkg::FLD_BYTES[i]))
            begin
                rd_data_d = fld_val[i][rd_off[1:0] * 8 +: 8];
                rd_mapped_d = 1'b1;
            end
        end
    end

    // Read data register; unmapped addresses read zero.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            rd_data_q <= 8'h00;
            rd_mapped_q <= 1'b0;
        end
        else
        begin
            rd_data_q <= rd_data_d;
            rd_mapped_q <= rd_mapped_d;
        end
    end

endmodule

/* verif/mbr_field_bank_props.sv */
// Port-level assertions for the multi-byte register field bank.
`timescale 1ns/1ps

module mbr_field_bank_props (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wr_valid,
    input wire logic [15:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [15:0] rd_addr,
    input wire logic [7:0] rd_data_q,
    input wire logic rd_mapped_q,
    input wire logic wr_miss_q,
    input wire logic [mbr_pkg::FLD_NUM-1:0] field_applied_q,
    input mbr_pkg::mbr_fields_s fields_q,
    input wire logic spi_mode_q,
    input wire logic device_selected_q,
    input wire logic clock_outputs_enable_q,
    input wire logic enable_pin_pullup_on_q,
    input wire logic enable_pin_pulldown_on_q,
    input wire logic ref_buffer_enable_q,
    input wire logic differential_ac_bias_on_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // A write counts only outside select mode or while the device is selected.
    logic taken;
    assign taken = wr_valid && (!spi_mode_q || device_selected_q);

    ////////////////////////////////////////
    // Write side.
    property p_dco_atomic;
        field_applied_q[mbr_pkg::FLD_DCO] |-> $past(taken) && $past(wr_addr) == mbr_pkg::DCO_WORD_BASE + 16'h3;
    endproperty
    a_dco_atomic: assert property (p_dco_atomic) else $error("dco applied without its top byte");
    property p_dco_hold;
        !field_applied_q[mbr_pkg::FLD_DCO] |-> $stable(fields_q.dco_word);
    endproperty
    a_dco_hold: assert property (p_dco_hold) else $error("dco changed while staged");
    property p_lock_lane;
        taken && wr_addr == mbr_pkg::LOCK_THR_BASE + 16'h1 |=> field_applied_q[mbr_pkg::FLD_LOCK]
            && fields_q.lock_thresh == {$past(wr_data), $past(fields_q.lock_thresh[7:0])};
    endproperty
    a_lock_lane: assert property (p_lock_lane) else $error("lock upper byte misplaced");
    property p_lock_low;
        taken && wr_addr == mbr_pkg::LOCK_THR_BASE |=> fields_q.lock_thresh[7:0] == $past(wr_data);
    endproperty
    a_lock_low: assert property (p_lock_low) else $error("lock low byte not applied at once");
    property p_outdiv_inst;
        taken && wr_addr == mbr_pkg::OUTDIV_BASE + 16'h11 |=> fields_q.outdiv[2][15:8] == $past(wr_data);
    endproperty
    a_outdiv_inst: assert property (p_outdiv_inst) else $error("divider instance 2 misdecoded");
    property p_gap_miss;
        taken && wr_addr == mbr_pkg::OUTDIV_BASE + 16'h2 |=> wr_miss_q && field_applied_q == '0;
    endproperty
    a_gap_miss: assert property (p_gap_miss) else $error("gap address decoded as a field");
    property p_refused;
        spi_mode_q && !device_selected_q && wr_valid |=> field_applied_q == '0 && !wr_miss_q;
    endproperty
    a_refused: assert property (p_refused) else $error("write taken while deselected");

    ////////////////////////////////////////
    // Read side, input buffer and pin controls.
    property p_read_old;
        rd_addr == mbr_pkg::LOCK_THR_BASE |=> rd_mapped_q && rd_data_q == $past(fields_q.lock_thresh[7:0]);
    endproperty
    a_read_old: assert property (p_read_old) else $error("lock read wrong");
    property p_refbuf;
        taken && wr_addr == mbr_pkg::REFIN_CFG_BASE |-> ##2 ref_buffer_enable_q == $past(wr_data[0], 2)
            && differential_ac_bias_on_q == ($past(wr_data[1], 2) & $past(wr_data[0], 2));
    endproperty
    a_refbuf: assert property (p_refbuf) else $error("input buffer controls wrong");
    property p_spi_pulls;
        spi_mode_q [*2] |-> clock_outputs_enable_q && enable_pin_pullup_on_q && !enable_pin_pulldown_on_q;
    endproperty
    a_spi_pulls: assert property (p_spi_pulls) else $error("pin controls wrong in select mode");

    // Main scenarios reached.
    c_dco: cover property (field_applied_q[mbr_pkg::FLD_DCO]);
    c_refused: cover property (spi_mode_q && !device_selected_q && wr_valid);
    c_miss: cover property (wr_miss_q);
endmodule

/* verif/mbr_host_model.sv */
// Host controller model driving the serial-port side of the field bank.
`timescale 1ns/1ps

module mbr_host_model (
    input wire logic clk,
    output logic spi_mode_pin,
    output logic shared_enable_select_pin,
    output logic wr_valid,
    output logic [15:0] wr_addr,
    output logic [7:0] wr_data
);
    // Idle levels at time zero: two-wire mode, pin high, no write.
    initial
    begin
        spi_mode_pin = 1'b0;
        shared_enable_select_pin = 1'b1;
        wr_valid = 1'b0;
        wr_addr = 16'h0000;
        wr_data = 8'h00;
    end

    ////////////////////////////////////////
    // Called just after an edge; in select mode the select pin is low around accepted writes and high around the refused one.
    task automatic set_pins(input logic mode, input logic pin);
        spi_mode_pin <= mode;
        shared_enable_select_pin <= pin;
    endtask

    // One byte per cycle; the last one releases the bus, whose lines then show no stale value.
    task automatic write_byte(input logic [15:0] a, input logic [7:0] d, input bit last);
        wr_valid <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge clk);
        if (last)
        begin
            wr_valid <= 1'b0;
            wr_addr <= ~a;
            wr_data <= ~d;
        end
    endtask
endmodule

/* verif/multibyte_register_update_tb.sv */
// Self-checking testbench of the multi-byte register field bank.
`timescale 1ns/1ps

module multibyte_register_update_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] rd_addr = 16'h0000;
    logic spi_mode_pin, shared_enable_select_pin, wr_valid;
    logic [15:0] wr_addr, base;
    logic [7:0] wr_data, rd_data_q, cfg;
    logic rd_mapped_q, wr_miss_q, spi_mode_q, device_selected_q, clock_outputs_enable_q;
    logic enable_pin_pullup_on_q, enable_pin_pulldown_on_q, ref_buffer_enable_q;
    logic differential_ac_bias_on_q, single_ended_bias_on_q;
    logic [mbr_pkg::FLD_NUM-1:0] field_applied_q;
    mbr_pkg::mbr_fields_s fields_q;
    logic [31:0] word;
    logic [15:0] lock_exp = 16'h0000;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 32'hb7a93c81;
    int lane;

    // 25 MHz clock.
    always #20 clk = ~clk;

    mbr_host_model u_host (.clk, .spi_mode_pin, .shared_enable_select_pin, .wr_valid, .wr_addr, .wr_data);
    mbr_field_bank DUT (.clk, .reset_n, .spi_mode_pin, .shared_enable_select_pin, .wr_valid, .wr_addr,
        .wr_data, .rd_addr, .rd_data_q, .rd_mapped_q, .wr_miss_q, .field_applied_q, .fields_q, .spi_mode_q,
        .device_selected_q, .clock_outputs_enable_q, .enable_pin_pullup_on_q, .enable_pin_pulldown_on_q,
        .ref_buffer_enable_q, .differential_ac_bias_on_q, .single_ended_bias_on_q);

    ////////////////////////////////////////
    // Expectations, comparison and closing report.
    function automatic logic exp_oe(input logic [7:0] c, input logic p);
        return (c[1:0] != 2'h0) ? 1'b1 : (p == c[2]);
    endfunction
    function automatic logic exp_bias(input logic [7:0] c, input int b);
        return c[b] & c[0];
    endfunction
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Let the edge's updates land before sampling.
    task automatic settle();
        @(posedge clk);
        #1;
    endtask
    task automatic wr1(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        u_host.write_byte(a, d, 1'b1);
    endtask
    task automatic rd(input logic [15:0] a, input string name, input logic [7:0] exp);
        @(posedge clk);
        rd_addr <= a;
        settle();
        check(name, 32'(exp), 32'(rd_data_q));
    endtask

    // A hang is cut short long after the sequence should have ended.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            summarize();
        end
    end

    ////////////////////////////////////////
    // Main sequence.
    initial
    begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        settle();
        check("buffer enable", 32'h1, 32'(ref_buffer_enable_q));
        check("outputs enable", 32'h1, 32'(clock_outputs_enable_q));
        rd(mbr_pkg::PIN_CFG_BASE, "pin cfg", 8'h0c);
        rd(mbr_pkg::REFIN_CFG_BASE, "refin cfg", 8'h01);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            word = $random(seed);
            lane = int'(word[8]);
            lock_exp[lane*8 +: 8] = word[7:0];
            wr1(mbr_pkg::LOCK_THR_BASE + 16'(lane), word[7:0]);
            settle();
            check("lock", 32'(lock_exp), 32'(fields_q.lock_thresh));
            rd(mbr_pkg::LOCK_THR_BASE + 16'(lane), "lock read", lock_exp[lane*8 +: 8]);
        end
        $display("test non-atomic done");
        word = $random(seed);
        @(posedge clk);
        for (int b = 0; b < 3; b++)
            u_host.write_byte(mbr_pkg::DCO_WORD_BASE + 16'(b), word[b*8 +: 8], b == 2);
        settle();
        check("dco staged", 32'h0, fields_q.dco_word);
        wr1(mbr_pkg::DCO_WORD_BASE + 16'h3, word[31:24]);
        // The apply strobe stands for one cycle only, so look just after the taking edge.
        #1;
        check("dco", word, fields_q.dco_word);
        check("dco pulse", 32'h1, 32'(field_applied_q[mbr_pkg::FLD_DCO]));
        for (int n = 0; n < 4; n++)
        begin
            word = $random(seed);
            base = mbr_pkg::OUTDIV_BASE + mbr_pkg::OUTDIV_STRIDE * 16'(n);
            wr1(base, word[7:0]);
            settle();
            check("divider staged", 32'h1, 32'(fields_q.outdiv[n]));
            wr1(base + 16'h1, word[15:8]);
            settle();
            check("divider", 32'(word[15:0]), 32'(fields_q.outdiv[n]));
        end
        wr1(mbr_pkg::OUTDIV_BASE + 16'h2, 8'h3c);
        #1;
        check("gap miss", 32'h1, 32'(wr_miss_q));
        $display("test atomic done");
        for (int v = 0; v < 8; v++)
        begin
            wr1(mbr_pkg::REFIN_CFG_BASE, 8'(v));
            settle();
            settle();
            check("buffer", 32'(v & 1), 32'(ref_buffer_enable_q));
            check("dc bias", 32'(exp_bias(8'(v), 1)), 32'(differential_ac_bias_on_q));
            check("self bias", 32'(exp_bias(8'(v), 2)), 32'(single_ended_bias_on_q));
        end
        $display("test input buffer done");
        for (int i = 0; i < 8; i++)
        begin
            word = $random(seed);
            cfg = word[7:0] & ((i % 2 == 0) ? 8'h1c : 8'h1f);
            wr1(mbr_pkg::PIN_CFG_BASE, cfg);
            u_host.set_pins(1'b0, word[8]);
            repeat (4) settle();
            check("outputs enable", 32'(exp_oe(cfg, word[8])), 32'(clock_outputs_enable_q));
            check("pull-up", 32'(cfg[3]), 32'(enable_pin_pullup_on_q));
            check("pull-down", 32'(cfg[4]), 32'(enable_pin_pulldown_on_q));
        end
        $display("test pin controls done");
        @(posedge clk);
        u_host.set_pins(1'b1, 1'b1);
        repeat (5) settle();
        check("selected", 32'h0, 32'(device_selected_q));
        // Data differs from the later accepted write, so a leak would show in the kept value.
        wr1(mbr_pkg::LOCK_THR_BASE, 8'ha5);
        #1;
        check("refused", 32'h0, 32'(field_applied_q));
        check("refused miss", 32'h0, 32'(wr_miss_q));
        check("lock kept", 32'(lock_exp), 32'(fields_q.lock_thresh));
        @(posedge clk);
        u_host.set_pins(1'b1, 1'b0);
        repeat (4) settle();
        check("selected", 32'h1, 32'(device_selected_q));
        wr1(mbr_pkg::LOCK_THR_BASE, 8'h5a);
        settle();
        lock_exp[7:0] = 8'h5a;
        check("lock", 32'(lock_exp), 32'(fields_q.lock_thresh));
        $display("test select mode done");
        summarize();
    end
endmodule

bind mbr_field_bank mbr_field_bank_props u_props (.clk, .reset_n, .wr_valid, .wr_addr, .wr_data, .rd_addr,
    .rd_data_q, .rd_mapped_q, .wr_miss_q, .field_applied_q, .fields_q, .spi_mode_q, .device_selected_q,
    .clock_outputs_enable_q, .enable_pin_pullup_on_q, .enable_pin_pulldown_on_q, .ref_buffer_enable_q,
    .differential_ac_bias_on_q);
